// ### audio_host_model.sv
`timescale 1ns/100ps
// Host side serial audio master; the bit clock stands low while halted
module audio_host_model (
  input  wire logic        run,
  input  wire logic [9:0]  n_bits,
  input  wire logic [1:0]  fmt,
  input  wire logic [8:0]  ofs,
  input  wire logic [31:0] left,
  input  wire logic [31:0] right,
  output logic             bclk,
  output logic             ws,
  output logic             sd
);
  import audio_port_pkg::*;
  int i;
  int n;
  int sl;
  int s0;
  int a;
  int b;
  ////////////////////////////////////////////////////////////////
  initial begin
    bclk = 1'b0;
    ws   = 1'b0;
    sd   = 1'b0;
    i    = 0;
    #7;
    forever begin
      if (run) begin
        n  = int'(n_bits);
        i  = i % n;
        sl = (fmt == FMT_TDM || n > 64) ? 32 : n / 2;
        s0 = (fmt == FMT_TDM) ? int'(ofs) : (fmt == FMT_I2S) ? 1 : 0;
        ws = (fmt == FMT_TDM) ? (i == 0) : ((i >= n / 2) == (fmt == FMT_I2S));
        a  = (i - s0 + n) % n;
        b  = (a - ((fmt == FMT_TDM) ? 32 : n / 2) + n) % n;
        // Right justified words sit at the slot end, so only low bits fit
        if (a < sl) sd = left[(fmt == FMT_RJ) ? sl - 1 - a : 31 - a];
        else if (b < sl) sd = right[(fmt == FMT_RJ) ? sl - 1 - b : 31 - b];
        else sd = ~sd;
        // Lines change only while the clock is low, stable at the rise
        #16 bclk = 1'b1;
        #16 bclk = 1'b0;
        i = i + 1;
      end else begin
        // Released data line must not look like a held value
        sd = ~sd;
        #16;
      end
    end
  end
endmodule

// ### audio_port_pkg.sv
package audio_port_pkg;
  // Register map
  localparam logic [7:0] REG_FORMAT    = 8'h33;
  localparam logic [7:0] REG_OFFSET    = 8'h34;
  localparam logic [7:0] REG_CLK_FAULT = 8'h71;
  localparam logic [7:0] FORMAT_RESET  = 8'h02;
  localparam logic [7:0] OFFSET_RESET  = 8'h00;
  // Format control fields
  localparam int FMT_HI  = 5;
  localparam int FMT_LO  = 4;
  localparam int SYNC_HI = 3;
  localparam int SYNC_LO = 2;
  localparam int WLEN_HI = 1;
  localparam int WLEN_LO = 0;
  localparam int OFS_TOP = 7;
  localparam logic [1:0] FMT_I2S = 2'h0;
  localparam logic [1:0] FMT_LJ  = 2'h1;
  localparam logic [1:0] FMT_RJ  = 2'h2;
  localparam logic [1:0] FMT_TDM = 2'h3;
  localparam logic [1:0] SYNC_SHORT = 2'h1;
  localparam logic [5:0] WORD_MAX   = 6'h20;
  // Clock fault status bits
  localparam int CF_HALT  = 0;
  localparam int CF_RATIO = 1;
  // Sample rate families
  localparam logic [1:0] RATE_32   = 2'h0;
  localparam logic [1:0] RATE_48   = 2'h1;
  localparam logic [1:0] RATE_96   = 2'h2;
  localparam logic [1:0] RATE_NONE = 2'h3;
  // Bit clocks per frame
  localparam logic [9:0] RATIO_32  = 10'h020;
  localparam logic [9:0] RATIO_64  = 10'h040;
  localparam logic [9:0] RATIO_128 = 10'h080;
  localparam logic [9:0] RATIO_256 = 10'h100;
  localparam logic [9:0] RATIO_512 = 10'h200;
  localparam logic [9:0] RATIO_SAT = 10'h3ff;
  // Timing
  localparam int CLK_PERIOD_NS    = 20;
  localparam int HALT_TIME_NS     = 5000;
  localparam int FRAME_96_MAX_NS  = 12000;
  localparam int FRAME_48_MAX_NS  = 26000;
  localparam int FRAME_32_MAX_NS  = 40000;
  localparam logic [8:0]  HALT_LAST  = 9'(HALT_TIME_NS / CLK_PERIOD_NS - 1);
  localparam logic [11:0] PER_96_MAX = 12'(FRAME_96_MAX_NS / CLK_PERIOD_NS);
  localparam logic [11:0] PER_48_MAX = 12'(FRAME_48_MAX_NS / CLK_PERIOD_NS);
  localparam logic [11:0] PER_32_MAX = 12'(FRAME_32_MAX_NS / CLK_PERIOD_NS);
  localparam logic [11:0] PER_SAT    = 12'hfff;

  function automatic logic [5:0] wl_bits(input logic [1:0] code);
    case (code)
      2'h0:    wl_bits = 6'h10;
      2'h1:    wl_bits = 6'h14;
      2'h2:    wl_bits = 6'h18;
      default: wl_bits = 6'h20;
    endcase
  endfunction
endpackage

// ### audio_slot_receiver.sv
`timescale 1ns/100ps
module audio_slot_receiver (
  input  wire logic        bclk,
  input  wire logic        rst_n,
  input  wire logic        ws,
  input  wire logic        sd,
  input  wire logic [7:0]  fmt_reg,
  input  wire logic [7:0]  ofs_reg,
  output logic      [31:0] word_q,
  output logic             word_right_q,
  output logic             word_tgl_q,
  output logic      [9:0]  ratio_q,
  output logic             ratio_tgl_q,
  output logic             alive_q
);
  import audio_port_pkg::*;

  logic [1:0]  rst_sync_q;
  logic [15:0] cfg_meta_q;
  logic [15:0] cfg_q;
  logic        link_rst;
  logic        ws_q;
  logic [9:0]  cnt_q, cnt_d;
  logic [9:0]  frame_q, frame_d;
  logic [31:0] sh_q, sh_d;
  logic [31:0] word_d;
  logic        word_right_d, word_tgl_d;
  logic [9:0]  ratio_d;
  logic        ratio_tgl_d;
  logic [1:0]  div_q;
  logic [1:0]  fmt;
  logic [5:0]  wl;
  logic [5:0]  sa;
  logic [9:0]  start;
  logic [9:0]  pos;
  logic        ws_edge, ws_rise, restart;

  // Reset and register settings enter the bit clock domain through two flops
  always_ff @(posedge bclk) begin
    rst_sync_q <= {rst_sync_q[0], rst_n};
    cfg_meta_q <= {fmt_reg, ofs_reg};
    cfg_q      <= cfg_meta_q;
  end
  assign link_rst = !rst_sync_q[1];

  assign fmt     = cfg_q[8 + FMT_HI : 8 + FMT_LO];
  assign wl      = wl_bits(cfg_q[8 + WLEN_HI : 8 + WLEN_LO]);
  assign sa      = WORD_MAX - wl;
  assign ws_edge = ws != ws_q;
  assign ws_rise = ws && !ws_q;
  assign restart = (fmt == FMT_TDM) ? ws_rise : ws_edge;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    sh_d         = {sh_q[30:0], sd};
    cnt_d        = (restart || cnt_q == RATIO_SAT) ? '0 : cnt_q + 10'h001;
    pos          = restart ? '0 : cnt_q + 10'h001;
    frame_d      = (frame_q == RATIO_SAT) ? frame_q : frame_q + 10'h001;
    ratio_d      = ratio_q;
    ratio_tgl_d  = ratio_tgl_q;
    word_d       = word_q;
    word_right_d = word_right_q;
    word_tgl_d   = word_tgl_q;
    if (fmt == FMT_TDM) begin
      start = {1'b0, cfg_q[8 + OFS_TOP], cfg_q[7:0]};
    end else if (fmt == FMT_I2S) begin
      start = 10'h001;
    end else begin
      start = 10'h000;
    end
    if (ws_rise) begin
      ratio_d     = frame_q;
      ratio_tgl_d = !ratio_tgl_q;
      frame_d     = 10'h001;
    end
    if (fmt == FMT_RJ) begin
      // Word ends on the bit before the word select change
      if (ws_edge) begin
        word_d       = sh_q << sa;
        word_right_d = !ws_q;
        word_tgl_d   = !word_tgl_q;
      end
    end else if (pos == start + 10'(wl) - 10'h001) begin
      word_d       = sh_d << sa;
      word_right_d = (fmt == FMT_I2S) ? ws : (fmt == FMT_LJ) ? !ws : 1'b0;
      word_tgl_d   = !word_tgl_q;
    end else if (fmt == FMT_TDM && pos == start + 10'({wl, 1'b0}) - 10'h001) begin
      word_d       = sh_d << sa;
      word_right_d = 1'b1;
      word_tgl_d   = !word_tgl_q;
    end
  end

  always_ff @(posedge bclk) begin
    if (link_rst) begin
      ws_q         <= 1'b0;
      cnt_q        <= '0;
      frame_q      <= '0;
      sh_q         <= '0;
      word_q       <= '0;
      word_right_q <= 1'b0;
      word_tgl_q   <= 1'b0;
      ratio_q      <= '0;
      ratio_tgl_q  <= 1'b0;
      div_q        <= '0;
    end else begin
      ws_q         <= ws;
      cnt_q        <= cnt_d;
      frame_q      <= frame_d;
      sh_q         <= sh_d;
      word_q       <= word_d;
      word_right_q <= word_right_d;
      word_tgl_q   <= word_tgl_d;
      ratio_q      <= ratio_d;
      ratio_tgl_q  <= ratio_tgl_d;
      div_q        <= div_q + 2'h1;
    end
  end
  // Divided so the system clock can still see it toggle at high ratios
  assign alive_q = div_q[1];

  ////////////////////////////////////////////////////////////////////////////
  a_i2s_channel: assert property (@(posedge bclk) disable iff (link_rst)
    (fmt == FMT_I2S && word_tgl_d != word_tgl_q) |=> word_right_q == $past(ws))
    else $error("I2S channel does not follow word select level");
  a_rj_channel: assert property (@(posedge bclk) disable iff (link_rst)
    (fmt == FMT_RJ && ws_edge) |=> (word_tgl_q != $past(word_tgl_q)) && word_right_q == ws_q)
    else $error("Right-justified word not emitted with inverted channel");
endmodule

// ### serial_audio_input_port.sv
`timescale 1ns/100ps
// Operation
// - Serial data bits are sampled on the rising bit clock edge.
// - Incoming bit clock is the only reference for internal clocking; here SYS_CLK also clocks I2C, clock monitor and rate detection.
// - Sample rate is detected automatically, 32 kHz to 96 kHz families.
// - I2S, left and right justified take 16-32 bits at 32 or 64 fs; here I2S captures no 32-bit word at 64 fs and no word at all at 32 fs.
// - TDM ratios: 128 at 32k, 128/256/512 at 48k, 128/256 at 96k.
// - Clock halt or unsupported ratio sets clock fault status.
// - Outputs go high impedance while serial clocks are halted.
// - On clock return the port resumes its prior state by itself.
// - Format field bits 5:4 pick I2S, left, right justified or TDM.
// - Samples are two's complement, MSB first, up to 32 bits.
// - Word length field bits 1:0 selects received sample length.
// - Nine-bit data offset from bit 7 and the offset register.
// - After reset the port runs I2S with 24-bit words.
// - TDM frame sync is at least one bit clock; rising edge starts frame.
// - I2S: low word select is left, high is right.
// - Right justified: high word select is left, low is right.
module serial_audio_input_port #(
  parameter logic [6:0] I2C_DEV_ADDR = 7'h2a  // Arbitrary value
) (
  input  wire logic        SYS_CLK,
  input  wire logic        RST_N,
  input  wire logic        BCLK,
  input  wire logic        WORD_SELECT_FRAME_SYNC,
  input  wire logic        SERIAL_DATA_IN,
  input  wire logic        I2C_SCL,
  input  wire logic        I2C_SDA_I,
  output logic             I2C_SDA_O,
  output logic             I2C_SDA_OE,
  output logic      [31:0] SAMPLE_DATA,
  output logic             SAMPLE_RIGHT,
  output logic             SAMPLE_VALID,
  output logic             OUT_HIZ,
  output logic      [1:0]  RATE_CODE,
  output logic      [9:0]  BCLK_RATIO
);
  import audio_port_pkg::*;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_ACK  = 6'h04,
    ST_WR   = 6'h08,
    ST_RD   = 6'h10,
    ST_RACK = 6'h20
  } i2c_e;
  logic [5:0]  s1_q, s2_q, s3_q;
  logic [31:0] lk_word;
  logic        lk_right, lk_wtgl, lk_rtgl, lk_alive;
  logic        scl_s, sda_s, scl_p, sda_p, scl_rise, scl_fall, i2c_start, i2c_stop;
  i2c_e        st_q, st_d;
  logic [2:0]  bitc_q, bitc_d;
  logic [7:0]  ish_q, ish_d, ptr_q, ptr_d;
  logic        rw_q, rw_d, first_q, first_d, done_q, done_d, oe_q, oe_d;
  logic [7:0]  fmt_q, fmt_d, ofs_q, ofs_d, fault, rd_data;
  logic [8:0]  idle_q, idle_d;
  logic [11:0] per_q, per_d;
  logic [1:0]  rate_q, rate_d;
  logic [9:0]  lk_ratio, ratio_q, ratio_d;
  logic [31:0] smp_q, smp_d;
  logic        right_q, right_d, valid_q, valid_d, halt_q, halt_d;
  logic        ratio_ok, hiz, alive_ev, ws_rise;
  ////////////////////////////////////////////////////////////////////////////
  // Link side: bit clock domain
  audio_slot_receiver u_rx (
    .bclk         (BCLK),
    .rst_n        (RST_N),
    .ws           (WORD_SELECT_FRAME_SYNC),
    .sd           (SERIAL_DATA_IN),
    .fmt_reg      (fmt_q),
    .ofs_reg      (ofs_q),
    .word_q       (lk_word),
    .word_right_q (lk_right),
    .word_tgl_q   (lk_wtgl),
    .ratio_q      (lk_ratio),
    .ratio_tgl_q  (lk_rtgl),
    .alive_q      (lk_alive)
  );
  // Pins and link toggles: two flops, third only for edge detection
  always_ff @(posedge SYS_CLK) begin
    s1_q <= {I2C_SCL, I2C_SDA_I, WORD_SELECT_FRAME_SYNC, lk_alive, lk_wtgl, lk_rtgl};
    s2_q <= s1_q;
    s3_q <= s2_q;
  end
  assign scl_s     = s2_q[5];
  assign sda_s     = s2_q[4];
  assign scl_p     = s3_q[5];
  assign sda_p     = s3_q[4];
  assign scl_rise  = scl_s && !scl_p;
  assign scl_fall  = !scl_s && scl_p;
  assign i2c_start = scl_s && scl_p && sda_p && !sda_s;
  assign i2c_stop  = scl_s && scl_p && !sda_p && sda_s;
  assign ws_rise   = s2_q[3] && !s3_q[3];
  assign alive_ev  = s2_q[2] != s3_q[2];
  ////////////////////////////////////////////////////////////////////////////
  // Register file
  assign fault = {6'h00, !ratio_ok, halt_q};
  always_comb begin
    if (ptr_q == REG_FORMAT) begin
      rd_data = fmt_q;
    end else if (ptr_q == REG_OFFSET) begin
      rd_data = ofs_q;
    end else if (ptr_q == REG_CLK_FAULT) begin
      rd_data = fault;
    end else begin
      rd_data = 8'h00;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // I2C slave; byte one sets the pointer, pointer auto-increments
  always_comb begin
    st_d    = st_q;
    bitc_d  = bitc_q;
    ish_d   = ish_q;
    ptr_d   = ptr_q;
    rw_d    = rw_q;
    first_d = first_q;
    done_d  = done_q;
    oe_d    = oe_q;
    fmt_d   = fmt_q;
    ofs_d   = ofs_q;
    if (i2c_start) begin
      st_d   = ST_ADDR;
      bitc_d = 3'h0;
      done_d = 1'b0;
      oe_d   = 1'b0;
    end else if (i2c_stop) begin
      st_d = ST_IDLE;
      oe_d = 1'b0;
    end else if (scl_rise) begin
      case (st_q)
        ST_ADDR, ST_WR: begin
          ish_d  = {ish_q[6:0], sda_s};
          bitc_d = bitc_q + 3'h1;
          done_d = bitc_q == 3'h7;
        end
        ST_RACK: begin
          if (sda_s) st_d = ST_IDLE;
        end
        default: ;
      endcase
    end else if (scl_fall) begin
      case (st_q)
        ST_ADDR: begin
          if (done_q) begin
            done_d = 1'b0;
            if (ish_q[7:1] == I2C_DEV_ADDR) begin
              rw_d    = ish_q[0];
              first_d = 1'b1;
              oe_d    = 1'b1;
              st_d    = ST_ACK;
            end else begin
              st_d = ST_IDLE;
            end
          end
        end
        ST_WR: begin
          if (done_q) begin
            done_d  = 1'b0;
            oe_d    = 1'b1;
            first_d = 1'b0;
            st_d    = ST_ACK;
            if (first_q) begin
              ptr_d = ish_q;
            end else begin
              ptr_d = ptr_q + 8'h01;
              // Fault status is read only; writes to it are dropped
              if (ptr_q == REG_FORMAT) begin
                fmt_d = ish_q;
              end else if (ptr_q == REG_OFFSET) begin
                ofs_d = ish_q;
              end
            end
          end
        end
        ST_ACK, ST_RACK: begin
          bitc_d = 3'h0;
          if (rw_q) begin
            ish_d = rd_data;
            ptr_d = ptr_q + 8'h01;
            oe_d  = !rd_data[7];
            st_d  = ST_RD;
          end else begin
            oe_d = 1'b0;
            st_d = ST_WR;
          end
        end
        ST_RD: begin
          if (bitc_q == 3'h7) begin
            oe_d = 1'b0;
            st_d = ST_RACK;
          end else begin
            bitc_d = bitc_q + 3'h1;
            ish_d  = {ish_q[6:0], 1'b0};
            oe_d   = !ish_q[6];
          end
        end
        default: ;
      endcase
    end
  end
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      st_q    <= ST_IDLE;
      bitc_q  <= 3'h0;
      ish_q   <= 8'h00;
      ptr_q   <= 8'h00;
      rw_q    <= 1'b0;
      first_q <= 1'b0;
      done_q  <= 1'b0;
      oe_q    <= 1'b0;
      fmt_q   <= FORMAT_RESET;
      ofs_q   <= OFFSET_RESET;
    end else begin
      st_q    <= st_d;
      bitc_q  <= bitc_d;
      ish_q   <= ish_d;
      ptr_q   <= ptr_d;
      rw_q    <= rw_d;
      first_q <= first_d;
      done_q  <= done_d;
      oe_q    <= oe_d;
      fmt_q   <= fmt_d;
      ofs_q   <= ofs_d;
    end
  end
  assign I2C_SDA_O  = 1'b0;
  assign I2C_SDA_OE = oe_q;
  ////////////////////////////////////////////////////////////////////////////
  // Clock monitor, rate detection and sample hand-off
  always_comb begin
    ratio_ok = 1'b0;
    if (rate_q != RATE_NONE) begin
      if (fmt_q[FMT_HI:FMT_LO] == FMT_TDM) begin
        ratio_ok = (ratio_q == RATIO_128) ||
                   (ratio_q == RATIO_256 && rate_q != RATE_32) ||
                   (ratio_q == RATIO_512 && rate_q == RATE_48);
      end else begin
        ratio_ok = (ratio_q == RATIO_32) || (ratio_q == RATIO_64);
      end
    end
  end
  assign hiz = halt_q || !ratio_ok;
  always_comb begin
    idle_d  = idle_q;
    halt_d  = halt_q;
    per_d   = (per_q == PER_SAT) ? per_q : per_q + 12'h001;
    rate_d  = (per_q == PER_SAT) ? RATE_NONE : rate_q;
    ratio_d = ratio_q;
    smp_d   = smp_q;
    right_d = right_q;
    valid_d = 1'b0;
    if (alive_ev) begin
      idle_d = 9'h000;
      halt_d = 1'b0;
    end else if (idle_q == HALT_LAST) begin
      halt_d = 1'b1;
    end else begin
      idle_d = idle_q + 9'h001;
    end
    if (ws_rise) begin
      per_d = 12'h001;
      if (per_q <= PER_96_MAX) begin
        rate_d = RATE_96;
      end else if (per_q <= PER_48_MAX) begin
        rate_d = RATE_48;
      end else if (per_q <= PER_32_MAX) begin
        rate_d = RATE_32;
      end else begin
        rate_d = RATE_NONE;
      end
    end
    // Link words are held stable for many system cycles after each toggle
    if (s2_q[0] != s3_q[0]) begin
      ratio_d = lk_ratio;
    end
    if (s2_q[1] != s3_q[1] && !hiz) begin
      smp_d   = lk_word;
      right_d = lk_right;
      valid_d = 1'b1;
    end
  end
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      idle_q  <= 9'h000;
      halt_q  <= 1'b1;
      per_q   <= 12'h000;
      rate_q  <= RATE_NONE;
      ratio_q <= 10'h000;
      smp_q   <= 32'h0000_0000;
      right_q <= 1'b0;
      valid_q <= 1'b0;
    end else begin
      idle_q  <= idle_d;
      halt_q  <= halt_d;
      per_q   <= per_d;
      rate_q  <= rate_d;
      ratio_q <= ratio_d;
      smp_q   <= smp_d;
      right_q <= right_d;
      valid_q <= valid_d;
    end
  end
  assign SAMPLE_DATA  = smp_q;
  assign SAMPLE_RIGHT = right_q;
  assign SAMPLE_VALID = valid_q;
  assign OUT_HIZ      = hiz;
  assign RATE_CODE    = rate_q;
  assign BCLK_RATIO   = ratio_q;
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  a_halt_hiz: assert property (halt_q |-> OUT_HIZ)
    else $error("Outputs not high impedance while clocks halted");
  a_hiz_no_sample: assert property (OUT_HIZ |=> !SAMPLE_VALID)
    else $error("Sample delivered while outputs high impedance");
  a_halt_status: assert property (halt_q == fault[CF_HALT])
    else $error("Halt not shown in clock fault status");
  a_halt_detect: assert property ((idle_q == HALT_LAST && !alive_ev) |=> halt_q)
    else $error("Halt not flagged after idle timeout");
  a_ratio_status: assert property (
    (rate_q == RATE_NONE) |-> fault[CF_RATIO] && OUT_HIZ)
    else $error("Unsupported clocking not flagged");
  a_auto_recover: assert property ((halt_q && alive_ev) |=> !halt_q ##0 fmt_q == $past(fmt_q))
    else $error("Port did not recover on clock return");
  a_rate_96: assert property ((ws_rise && per_q <= PER_96_MAX) |=> rate_q == RATE_96)
    else $error("Fast frame period not detected as 96 kHz family");
  a_reset_format: assert property ($rose(RST_N) |-> fmt_q == FORMAT_RESET)
    else $error("Format register not at its reset value");
  c_halt: cover property ($rose(halt_q));
  c_recover: cover property ($fell(halt_q));
  c_right: cover property (SAMPLE_VALID && SAMPLE_RIGHT);
endmodule

// ### tb.sv
`timescale 1ns/100ps
module tb;
  import audio_port_pkg::*;
  localparam logic [6:0]  DEV = 7'h2a; // Arbitrary value
  localparam logic [31:0] LW  = 32'h8a5c_3e71;
  localparam logic [31:0] RW  = 32'h65b2_d90f;
  logic        SYS_CLK;
  logic        RST_N;
  logic        scl;
  logic        m_sda;
  logic        run;
  logic [9:0]  n_bits;
  logic [8:0]  ofs;
  logic [7:0]  cur_fmt;
  logic        bclk;
  logic        ws;
  logic        sd;
  logic        sda_o;
  logic        sda_oe;
  logic [31:0] s_data;
  logic        s_right;
  logic        s_valid;
  logic        hiz;
  logic [1:0]  rate;
  logic [9:0]  ratio;
  wire         sda;
  int          n_fail;
  int          n_checks;
  int          n_valid;
  assign sda = m_sda & ~(sda_oe & ~sda_o);
  ////////////////////////////////////////////////////////////////
  serial_audio_input_port #(.I2C_DEV_ADDR(DEV)) uut (
    .SYS_CLK(SYS_CLK), .RST_N(RST_N), .BCLK(bclk), .WORD_SELECT_FRAME_SYNC(ws),
    .SERIAL_DATA_IN(sd), .I2C_SCL(scl), .I2C_SDA_I(sda), .I2C_SDA_O(sda_o),
    .I2C_SDA_OE(sda_oe), .SAMPLE_DATA(s_data), .SAMPLE_RIGHT(s_right),
    .SAMPLE_VALID(s_valid), .OUT_HIZ(hiz), .RATE_CODE(rate), .BCLK_RATIO(ratio));
  audio_host_model host (
    .run(run), .n_bits(n_bits), .fmt(cur_fmt[5:4]), .ofs(ofs), .left(LW),
    .right(RW), .bclk(bclk), .ws(ws), .sd(sd));
  ////////////////////////////////////////////////////////////////
  initial begin
    SYS_CLK = 1'b0;
    forever #10 SYS_CLK = ~SYS_CLK;
  end
  always @(negedge SYS_CLK) begin
    if (s_valid === 1'b1) n_valid++;
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge SYS_CLK);
  endtask
  task automatic i2c_bit(input logic bt, output logic r);
    tick(1);
    m_sda = bt;
    tick(5);
    scl = 1'b1;
    tick(3);
    r = sda;
    tick(3);
    scl = 1'b0;
  endtask
  // Start when s is 1, stop when 0
  task automatic i2c_cond(input logic s);
    tick(1);
    m_sda = s;
    tick(6);
    scl = 1'b1;
    tick(6);
    m_sda = ~s;
    tick(6);
    if (s) scl = 1'b0;
  endtask
  task automatic i2c_byte(input logic [7:0] tx, output logic [7:0] rx);
    logic a;
    for (int k = 7; k >= 0; k--) i2c_bit(tx[k], rx[k]);
    i2c_bit(1'b1, a);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] x;
    i2c_cond(1'b1);
    i2c_byte({DEV, 1'b0}, x);
    i2c_byte(a, x);
    i2c_byte(d, x);
    i2c_cond(1'b0);
  endtask
  task automatic regchk(input logic [7:0] a, input logic [7:0] e, input string what);
    logic [7:0] x;
    logic [7:0] d;
    i2c_cond(1'b1);
    i2c_byte({DEV, 1'b0}, x);
    i2c_byte(a, x);
    i2c_cond(1'b1);
    i2c_byte({DEV, 1'b1}, x);
    i2c_byte(8'hff, d);
    i2c_cond(1'b0);
    chk(what, {24'h0, d}, {24'h0, e});
  endtask
  function automatic logic [31:0] expw(input logic [31:0] w);
    int len;
    len = (cur_fmt[1:0] == 2'h3) ? 32 : 16 + 4 * int'(cur_fmt[1:0]);
    if (cur_fmt[5:4] == FMT_RJ) return w << (32 - len);
    return w & ~(32'hffffffff >> len);
  endfunction
  task automatic grab(output logic r, output logic [31:0] d);
    int k;
    k = 0;
    while (s_valid !== 1'b1 && k < 4000) begin
      tick(1);
      k++;
    end
    chk("sample wait", {31'h0, k < 4000}, 32'h1);
    r = s_right;
    d = s_data;
    tick(1);
  endtask
  task automatic check_pair();
    logic r;
    logic [31:0] d;
    grab(r, d);
    if (r !== 1'b0) grab(r, d);
    chk("left flag", {31'h0, r}, 32'h0);
    chk("left word", d, expw(LW));
    grab(r, d);
    chk("right flag", {31'h0, r}, 32'h1);
    chk("right word", d, expw(RW));
  endtask
  task automatic wait_live();
    int k;
    k = 0;
    while (hiz !== 1'b0 && k < 3000) begin
      tick(1);
      k++;
    end
    chk("hiz live", {31'h0, hiz}, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_regs();
    wait_live();
    regchk(REG_FORMAT, 8'h02, "format reset");
    regchk(REG_OFFSET, 8'h00, "offset reset");
    wr(REG_OFFSET, 8'ha5);
    regchk(REG_OFFSET, 8'ha5, "offset rw");
    wr(REG_OFFSET, 8'h00);
    wr(REG_CLK_FAULT, 8'hff);
    regchk(REG_CLK_FAULT, 8'h00, "fault ro");
    wr(8'h50, 8'h5a);
    regchk(8'h50, 8'h00, "unmapped");
    $display("Test regs done");
  endtask
  task automatic t_stream(input logic [7:0] f, input logic [7:0] o, input logic [9:0] nb);
    // Both clocks stop over 100 us before the ratio changes
    run = 1'b0;
    tick(5050);
    n_bits = nb;
    ofs = {f[7], o};
    cur_fmt = f;
    run = 1'b1;
    // Registers are written only once the clocks are stable
    tick(300);
    wr(REG_FORMAT, f);
    wr(REG_OFFSET, o);
    wait_live();
    tick(1200);
    chk("ratio", {22'h0, ratio}, {22'h0, nb});
    chk("rate", {30'h0, rate}, (int'(nb) * 32 / 20 <= 600) ? 32'h2 : 32'h1);
    check_pair();
    $display("Test stream %h ratio %0d done", f, nb);
  endtask
  task automatic t_halt();
    int nv;
    run = 1'b0;
    tick(300);
    nv = n_valid;
    chk("hiz halted", {31'h0, hiz}, 32'h1);
    regchk(REG_CLK_FAULT, 8'h01, "halt fault");
    chk("halt samples", n_valid - nv, 0);
    run = 1'b1;
    wait_live();
    regchk(REG_FORMAT, cur_fmt, "format kept");
    check_pair();
    $display("Test halt done");
  endtask
  task automatic t_bad_ratio();
    int nv;
    run = 1'b0;
    tick(5050);
    n_bits = 10'h080;
    cur_fmt = 8'h02;
    run = 1'b1;
    tick(1000);
    wr(REG_FORMAT, 8'h02);
    tick(1000);
    nv = n_valid;
    chk("hiz ratio", {31'h0, hiz}, 32'h1);
    regchk(REG_CLK_FAULT, 8'h02, "ratio fault");
    chk("ratio samples", n_valid - nv, 0);
    $display("Test bad ratio done");
  endtask
  task automatic conclude();
    $display("Checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    n_fail = 0;
    n_checks = 0;
    n_valid = 0;
    RST_N = 1'b0;
    scl = 1'b1;
    m_sda = 1'b1;
    run = 1'b1;
    n_bits = 10'h040;
    ofs = 9'h0;
    cur_fmt = 8'h02;
    tick(6);
    RST_N = 1'b1;
    t_regs();
    t_stream(8'h02, 8'h00, 10'h040);
    t_stream(8'h20, 8'h00, 10'h020);
    t_stream(8'h11, 8'h00, 10'h040);
    t_stream(8'h37, 8'h01, 10'h080);
    t_stream(8'h37, 8'h00, 10'h200);
    t_halt();
    t_bad_ratio();
    conclude();
  end
  // Tests take about 53000 cycles; a hang is cut at 85000
  initial begin
    #1_700_000;
    n_fail++;
    conclude();
  end
endmodule
